/* hdl/psb_unit.sv */
// stack and bit test execution unit of the plc sequencer datapath
`timescale 1ns/10ps
module psb_unit #(
  parameter int unsigned DEPTH = psb_pkg::STACK_DEPTH
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // command from sequencer
  input  wire logic                         cmdValid,
  input  wire psb_pkg::psb_cmd_t            cmdCode,
  input  wire logic                         useImmediate,
  input  wire logic [psb_pkg::WORD_W-1:0]   immValue,
  input  wire logic [psb_pkg::WORD_W-1:0]   operandValue,
  input  wire psb_pkg::psb_size_t           operandSize,
  input  wire logic                         operandBit,
  // accumulators
  output logic [psb_pkg::WORD_W-1:0]        wordAcc,
  output logic                              logicAcc,
  // pull results to operand storage
  output logic                              pullValid,
  output logic                              pullIsBit,
  output logic                              pullBit,
  output logic [psb_pkg::WORD_W-1:0]        pullWord,
  // completion and errors
  output logic                              cmdDone,
  output logic                              overflowErr,
  output logic                              emptyErr,
  output logic [$clog2(DEPTH+1)-1:0]        stackLevel
);
  localparam int unsigned PTR_W = $clog2(DEPTH + 1);
  localparam int unsigned IDX_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ZERO = '0;
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(DEPTH);

  typedef struct packed {
    psb_pkg::psb_state_t        state;
    logic [psb_pkg::WORD_W-1:0] wordAcc;
    logic                       logicAcc;
    logic [PTR_W-1:0]           ptr;
    logic                       pullValid;
    logic                       pullIsBit;
    logic                       pullBit;
    logic [psb_pkg::WORD_W-1:0] pullWord;
    logic                       done;
    logic                       overflowErr;
    logic                       emptyErr;
  } psb_unit_t;

  psb_unit_t s_q;
  psb_unit_t s_d;

  // sign extension of narrow operands from their top bit
  function automatic logic [psb_pkg::WORD_W-1:0] sign_extend(
    input logic [psb_pkg::WORD_W-1:0] v,
    input psb_pkg::psb_size_t         sz
  );
    logic [psb_pkg::WORD_W-1:0] r;
    r = v;
    case (sz)
      psb_pkg::PSB_SZ_BYTE: begin
        r = {{(psb_pkg::WORD_W-psb_pkg::SRC_B){v[psb_pkg::SRC_B-1]}},
             v[psb_pkg::SRC_B-1:0]};
      end
      psb_pkg::PSB_SZ_WORD: begin
        r = {{(psb_pkg::WORD_W-psb_pkg::SRC_W){v[psb_pkg::SRC_W-1]}},
             v[psb_pkg::SRC_W-1:0]};
      end
      default: begin
        r = v;
      end
    endcase
    return r;
  endfunction : sign_extend

  // single-bit values sit at bit 7, the rest of the word zero
  function automatic logic [psb_pkg::WORD_W-1:0] bit_entry(input logic b);
    logic [psb_pkg::WORD_W-1:0] r;
    r = '0;
    r[psb_pkg::LOGIC_POS] = b;
    return r;
  endfunction : bit_entry

  logic [psb_pkg::WORD_W-1:0] bitIndex;
  logic                       bitTested;
  logic [psb_pkg::WORD_W-1:0] bitSetWord;
  logic [psb_pkg::WORD_W-1:0] bitClearWord;
  logic                       memWrEn;
  logic [IDX_W-1:0]           memWrIdx;
  logic [psb_pkg::WORD_W-1:0] memWrData;
  logic [IDX_W-1:0]           memRdIdx;
  logic [psb_pkg::WORD_W-1:0] memRdData;
  logic                       isPush;
  logic                       isPull;
  logic                       stackFull;
  logic                       stackEmpty;

  assign bitIndex = useImmediate ? immValue : operandValue;

  psb_bit_sel #(
    .WIDTH     (psb_pkg::WORD_W)
  ) u_bit_sel (
    .word      (s_q.wordAcc),
    .index     (bitIndex),
    .tested    (bitTested),
    .setWord   (bitSetWord),
    .clearWord (bitClearWord)
  );

  psb_stack_mem #(
    .WIDTH   (psb_pkg::WORD_W),
    .DEPTH   (DEPTH)
  ) u_stack_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (memWrEn),
    .wrIdx   (memWrIdx),
    .wrData  (memWrData),
    .rdIdx   (memRdIdx),
    .rdData  (memRdData)
  );

  assign stackFull  = (s_q.ptr == PTR_FULL);
  assign stackEmpty = (s_q.ptr == PTR_ZERO);
  assign memWrIdx   = s_q.ptr[IDX_W-1:0];
  // top entry sits one below the pointer
  assign memRdIdx   = IDX_W'(s_q.ptr - PTR_ONE);

  always_comb begin
    isPush = 1'b0;
    isPull = 1'b0;
    memWrData = '0;
    case (cmdCode)
      psb_pkg::PSB_CMD_PUSH_LOGIC: begin
        isPush    = 1'b1;
        memWrData = bit_entry(operandBit);
      end
      psb_pkg::PSB_CMD_PUSH_LACC: begin
        isPush    = 1'b1;
        memWrData = bit_entry(s_q.logicAcc);
      end
      psb_pkg::PSB_CMD_PUSH_WORD: begin
        isPush    = 1'b1;
        memWrData = sign_extend(useImmediate ? immValue : operandValue,
                                operandSize);
      end
      psb_pkg::PSB_CMD_PUSH_WACC: begin
        isPush    = 1'b1;
        memWrData = s_q.wordAcc;
      end
      psb_pkg::PSB_CMD_PULL_LOGIC,
      psb_pkg::PSB_CMD_PULL_WORD,
      psb_pkg::PSB_CMD_PULL_LACC,
      psb_pkg::PSB_CMD_PULL_WACC: begin
        isPull = 1'b1;
      end
      default: begin
        isPush = 1'b0;
      end
    endcase
  end

  // a refused push writes nothing, so the top entry is kept
  assign memWrEn = (s_q.state == psb_pkg::PSB_ST_IDLE) && cmdValid && isPush
                   && !stackFull;

  always_comb begin
    s_d = s_q;
    s_d.done      = 1'b0;
    s_d.pullValid = 1'b0;
    case (s_q.state)
      psb_pkg::PSB_ST_IDLE: begin
        if (cmdValid) begin
          s_d.state       = psb_pkg::PSB_ST_DONE;
          s_d.done        = 1'b1;
          s_d.overflowErr = 1'b0;
          s_d.emptyErr    = 1'b0;
          // shared push/pull path; every entry is a full word, only the data source or destination differs
          if (isPush) begin
            if (stackFull) begin
              s_d.overflowErr = 1'b1;
            end else begin
              s_d.ptr = PTR_W'(s_q.ptr + PTR_ONE);
            end
          end else if (isPull) begin
            if (stackEmpty) begin
              s_d.emptyErr = 1'b1;
            end else begin
              s_d.ptr = PTR_W'(s_q.ptr - PTR_ONE);
              case (cmdCode)
                psb_pkg::PSB_CMD_PULL_LOGIC: begin
                  s_d.pullValid = 1'b1;
                  s_d.pullIsBit = 1'b1;
                  s_d.pullBit   = memRdData[psb_pkg::LOGIC_POS];
                end
                psb_pkg::PSB_CMD_PULL_WORD: begin
                  s_d.pullValid = 1'b1;
                  s_d.pullIsBit = 1'b0;
                  s_d.pullWord  = memRdData;
                end
                psb_pkg::PSB_CMD_PULL_LACC: begin
                  s_d.logicAcc = memRdData[psb_pkg::LOGIC_POS];
                end
                default: begin
                  s_d.wordAcc = memRdData;
                end
              endcase
            end
          end else begin
            case (cmdCode)
              psb_pkg::PSB_CMD_BIT_TEST: begin
                s_d.logicAcc = bitTested;
              end
              psb_pkg::PSB_CMD_BIT_SET: begin
                s_d.wordAcc = bitSetWord;
              end
              psb_pkg::PSB_CMD_BIT_CLEAR: begin
                s_d.wordAcc = bitClearWord;
              end
              psb_pkg::PSB_CMD_LOAD_WACC: begin
                s_d.wordAcc = operandValue;
              end
              psb_pkg::PSB_CMD_LOAD_LACC: begin
                s_d.logicAcc = operandBit;
              end
              default: begin
                s_d.done = 1'b1;
              end
            endcase
          end
        end
      end
      psb_pkg::PSB_ST_DONE: begin
        // one idle cycle between commands keeps the read port stable
        s_d.state = psb_pkg::PSB_ST_IDLE;
      end
      default: begin
        s_d.state = psb_pkg::PSB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q       <= '0;
      s_q.state <= psb_pkg::PSB_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wordAcc     = s_q.wordAcc;
  assign logicAcc    = s_q.logicAcc;
  assign pullValid   = s_q.pullValid;
  assign pullIsBit   = s_q.pullIsBit;
  assign pullBit     = s_q.pullBit;
  assign pullWord    = s_q.pullWord;
  assign cmdDone     = s_q.done;
  assign overflowErr = s_q.overflowErr;
  assign emptyErr    = s_q.emptyErr;
  assign stackLevel  = s_q.ptr;
endmodule : psb_unit

/* hdl/psb_pkg.sv */
// constants and command codes of the stack and bit test unit
package psb_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned BIT_IDX_W   = 5;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned LOGIC_POS   = 7;
  localparam int unsigned SRC_B       = 8;
  localparam int unsigned SRC_W       = 16;

  typedef enum logic [3:0] {
    PSB_CMD_NONE        = 4'h0,
    PSB_CMD_BIT_TEST    = 4'h1,
    PSB_CMD_BIT_SET     = 4'h2,
    PSB_CMD_BIT_CLEAR   = 4'h3,
    PSB_CMD_PUSH_LOGIC  = 4'h4,
    PSB_CMD_PUSH_WORD   = 4'h5,
    PSB_CMD_PUSH_LACC   = 4'h6,
    PSB_CMD_PUSH_WACC   = 4'h7,
    PSB_CMD_PULL_LOGIC  = 4'h8,
    PSB_CMD_PULL_WORD   = 4'h9,
    PSB_CMD_PULL_LACC   = 4'ha,
    PSB_CMD_PULL_WACC   = 4'hb,
    PSB_CMD_LOAD_WACC   = 4'hc,
    PSB_CMD_LOAD_LACC   = 4'hd
  } psb_cmd_t;

  // operand width for word-level push
  typedef enum logic [1:0] {
    PSB_SZ_BYTE  = 2'h0,
    PSB_SZ_WORD  = 2'h1,
    PSB_SZ_DWORD = 2'h2
  } psb_size_t;

  typedef enum logic [0:0] {
    PSB_ST_IDLE = 1'h0,
    PSB_ST_DONE = 1'h1
  } psb_state_t;
endpackage : psb_pkg

/* hdl/psb_bit_sel.sv */
// bit index reduction and single-bit select/modify of a word
`timescale 1ns/10ps
module psb_bit_sel #(
  parameter int unsigned WIDTH = psb_pkg::WORD_W
) (
  // operand
  input  wire logic [WIDTH-1:0]                  word,
  input  wire logic [psb_pkg::WORD_W-1:0]        index,
  // results
  output logic                                   tested,
  output logic [WIDTH-1:0]                       setWord,
  output logic [WIDTH-1:0]                       clearWord
);
  logic [psb_pkg::BIT_IDX_W-1:0] pos;

  // low five bits are the index modulo 32
  always_comb begin
    pos       = index[psb_pkg::BIT_IDX_W-1:0];
    tested    = word[pos];
    setWord   = word;
    setWord[pos] = 1'b1;
    clearWord = word;
    clearWord[pos] = 1'b0;
  end
endmodule : psb_bit_sel

/* hdl/psb_stack_mem.sv */
// lifo storage of full-word stack entries
`timescale 1ns/10ps
module psb_stack_mem #(
  parameter int unsigned WIDTH = psb_pkg::WORD_W,
  parameter int unsigned DEPTH = psb_pkg::STACK_DEPTH
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input  wire logic [WIDTH-1:0]         wrData,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic [WIDTH-1:0]              rdData
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } psb_mem_t;

  psb_mem_t s_q;
  psb_mem_t s_d;

  always_comb begin
    s_d = s_q;
    if (wrEn) begin
      s_d.mem[wrIdx] = wrData;
    end
  end

  // contents cleared as well, though the pointer alone defines what is valid
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.mem[rdIdx];
endmodule : psb_stack_mem

/* tb/psb_assertions.sv */
// port-level checks of the stack and bit test unit
`timescale 1ns/10ps
module psb_assertions #(
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         reset_n,
  // watched ports
  input wire logic                         cmdValid,
  input wire logic                         cmdDone,
  input wire logic                         overflowErr,
  input wire logic                         emptyErr,
  input wire logic                         pullValid,
  input wire logic                         logicAcc,
  input wire logic [psb_pkg::WORD_W-1:0]   wordAcc,
  input wire logic [$clog2(DEPTH+1)-1:0]   stackLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_done_pulse; cmdDone |=> !cmdDone; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_taken; cmdDone |-> $past(cmdValid); endproperty
  a_taken: assert property (p_taken) else $error("done without command");
  property p_ovf; cmdDone && overflowErr |-> stackLevel == DEPTH && $stable(stackLevel);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow when not full");
  property p_empty; cmdDone && emptyErr |-> stackLevel == 0 && !pullValid; endproperty
  a_empty: assert property (p_empty) else $error("empty error when not empty");
  property p_step;
    $changed(stackLevel) |-> cmdDone &&
      (stackLevel == $past(stackLevel) + 1 || stackLevel + 1 == $past(stackLevel));
  endproperty
  a_step: assert property (p_step) else $error("level moved wrongly");
  property p_bound; stackLevel <= DEPTH; endproperty
  a_bound: assert property (p_bound) else $error("level above depth");
  property p_lacc; $changed(logicAcc) |-> cmdDone; endproperty
  a_lacc: assert property (p_lacc) else $error("logic acc moved alone");
  property p_wacc; $changed(wordAcc) |-> cmdDone; endproperty
  a_wacc: assert property (p_wacc) else $error("word acc moved alone");
  property p_pull; pullValid |-> cmdDone && !overflowErr; endproperty
  a_pull: assert property (p_pull) else $error("stray pull result");
endmodule : psb_assertions

bind psb_unit psb_assertions #(.DEPTH(DEPTH)) i_chk (.clk(clk), .reset_n(reset_n),
  .cmdValid(cmdValid), .cmdDone(cmdDone), .overflowErr(overflowErr), .emptyErr(emptyErr),
  .pullValid(pullValid), .logicAcc(logicAcc), .wordAcc(wordAcc), .stackLevel(stackLevel));

/* tb/psb_seq_model.sv */
// sequencer model issuing one command at a time
`timescale 1ns/10ps
module psb_seq_model (
  // clock and answers
  input wire logic             clk,
  input wire logic             cmdDone,
  input wire logic             pullValid,
  // command
  output logic                 cmdValid,
  output psb_pkg::psb_cmd_t    cmdCode,
  output logic                 useImmediate,
  output logic [31:0]          immValue,
  output logic [31:0]          operandValue,
  output psb_pkg::psb_size_t   operandSize,
  output logic                 operandBit
);
  logic pulsed;
  logic timedOut;
  initial begin
    {cmdValid, useImmediate, operandBit, immValue, operandValue} = '0;
    cmdCode = psb_pkg::PSB_CMD_NONE;
    operandSize = psb_pkg::PSB_SZ_BYTE;
  end
  task automatic issue(input psb_pkg::psb_cmd_t c, input logic im, input logic [31:0] iv,
                       input logic [31:0] ov, input psb_pkg::psb_size_t sz, input logic b);
    int n;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    useImmediate <= im;
    immValue <= iv;
    operandValue <= ov;
    operandSize <= sz;
    operandBit <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmdDone !== 1'b1 && n < 8);
    pulsed = pullValid;
    timedOut = (n >= 8);
    cmdValid <= 1'b0;
    // stale operands go inverted so nothing leans on a held value
    immValue <= ~iv;
    operandValue <= ~ov;
    operandBit <= ~b;
  endtask : issue
endmodule : psb_seq_model

/* tb/tb_top.sv */
// self-checking bench of the stack and bit test unit
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned DEPTH = 4;
  logic clk, reset_n, cmdValid, useImmediate, operandBit, logicAcc;
  logic pullValid, pullIsBit, pullBit, cmdDone, overflowErr, emptyErr;
  logic [31:0] immValue, operandValue, wordAcc, pullWord;
  logic [2:0] stackLevel;
  psb_pkg::psb_cmd_t cmdCode;
  psb_pkg::psb_size_t operandSize;
  int fails = 0;
  int checked = 0;
  psb_seq_model i_seq (.clk(clk), .cmdDone(cmdDone), .pullValid(pullValid),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .useImmediate(useImmediate),
    .immValue(immValue), .operandValue(operandValue), .operandSize(operandSize),
    .operandBit(operandBit));
  psb_unit #(.DEPTH(DEPTH)) i_dut (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .useImmediate(useImmediate), .immValue(immValue),
    .operandValue(operandValue), .operandSize(operandSize), .operandBit(operandBit),
    .wordAcc(wordAcc), .logicAcc(logicAcc), .pullValid(pullValid), .pullIsBit(pullIsBit),
    .pullBit(pullBit), .pullWord(pullWord), .cmdDone(cmdDone), .overflowErr(overflowErr),
    .emptyErr(emptyErr), .stackLevel(stackLevel));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask : cmp_bit
  task automatic go(input psb_pkg::psb_cmd_t c, input logic im, input logic [31:0] iv,
                    input logic [31:0] ov, input psb_pkg::psb_size_t sz, input logic b);
    i_seq.issue(c, im, iv, ov, sz, b);
    if (i_seq.timedOut) begin
      fails++;
      $display("BAD cmdDone exp 1 got 0");
      report_and_stop();
    end
  endtask : go
  // load both sources alike: only operandValue feeds the accumulator, useImmediate is ignored
  task automatic ld(input logic [31:0] v);
    go(psb_pkg::PSB_CMD_LOAD_WACC, 1'b1, v, v, psb_pkg::PSB_SZ_DWORD, 1'b0);
  endtask : ld
  task automatic t_bits();
    ld(32'h00003e81);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b1, 32'h0, 32'h1, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_bit("test0", 1'b1, logicAcc);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b0, 32'h0, 32'h21, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_bit("test33", 1'b0, logicAcc);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b1, 32'h27, 32'h1, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_bit("test39", 1'b1, logicAcc);
    go(psb_pkg::PSB_CMD_BIT_CLEAR, 1'b1, 32'h0, 32'h7, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_word("clear0", 32'h00003e80, wordAcc);
    go(psb_pkg::PSB_CMD_BIT_SET, 1'b0, 32'h0, 32'h3f, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_word("set63", 32'h80003e80, wordAcc);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b1, 32'h1f, 32'h0, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_bit("test31", 1'b1, logicAcc);
  endtask : t_bits
  task automatic t_words();
    logic [31:0] v[4] = '{32'h12345680, 32'h12347fff, 32'h80000001, 32'h000000ff};
    logic [31:0] e[4] = '{32'hffffff80, 32'h00007fff, 32'h80000001, 32'hffffffff};
    psb_pkg::psb_size_t s[4] = '{psb_pkg::PSB_SZ_BYTE, psb_pkg::PSB_SZ_WORD,
                                 psb_pkg::PSB_SZ_DWORD, psb_pkg::PSB_SZ_BYTE};
    ld(32'h1a443e18);
    go(psb_pkg::PSB_CMD_PUSH_WACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_word("pushkeep", 32'h1a443e18, wordAcc);
    cmp_word("lvl1", 32'h1, 32'(stackLevel));
    ld(32'h0);
    go(psb_pkg::PSB_CMD_PULL_WACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_word("pullwacc", 32'h1a443e18, wordAcc);
    for (int i = 0; i < 4; i++) begin
      // last entry is an immediate push, with a decoy on the operand side
      go(psb_pkg::PSB_CMD_PUSH_WORD, i == 3, v[i], i == 3 ? 32'h1 : v[i], s[i], 1'b0);
      go(psb_pkg::PSB_CMD_PULL_WORD, 1'b0, 32'h0, 32'h0, s[i], 1'b0);
      cmp_word("pullword", e[i], pullWord);
      cmp_bit("wordpulse", 1'b1, i_seq.pulsed & ~pullIsBit);
    end
  endtask : t_words
  task automatic t_logic();
    go(psb_pkg::PSB_CMD_PUSH_LOGIC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b1);
    go(psb_pkg::PSB_CMD_PUSH_LOGIC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    ld(32'h1);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b1, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    go(psb_pkg::PSB_CMD_PUSH_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    ld(32'h0);
    go(psb_pkg::PSB_CMD_BIT_TEST, 1'b1, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    go(psb_pkg::PSB_CMD_PULL_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("pulllacc", 1'b1, logicAcc);
    go(psb_pkg::PSB_CMD_PULL_LOGIC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b1);
    cmp_bit("pullbit", 1'b0, pullBit);
    cmp_bit("bitpulse", 1'b1, i_seq.pulsed & pullIsBit);
    go(psb_pkg::PSB_CMD_PULL_WORD, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_DWORD, 1'b0);
    cmp_word("bitentry", 32'h00000080, pullWord);
  endtask : t_logic
  task automatic t_errors();
    go(psb_pkg::PSB_CMD_PULL_WACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("empty", 1'b1, emptyErr);
    go(psb_pkg::PSB_CMD_LOAD_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b1);
    cmp_bit("lacc1", 1'b1, logicAcc);
    for (int i = 0; i < DEPTH; i++)
      go(psb_pkg::PSB_CMD_PUSH_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    // refused push carries a zero, so a stray write would show at the bottom
    go(psb_pkg::PSB_CMD_LOAD_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("lacc0", 1'b0, logicAcc);
    go(psb_pkg::PSB_CMD_PUSH_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("ovf", 1'b1, overflowErr);
    cmp_word("lvlfull", DEPTH, 32'(stackLevel));
    go(psb_pkg::PSB_CMD_PULL_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("ovfclr", 1'b0, overflowErr | emptyErr);
    cmp_bit("pulltop", 1'b1, logicAcc);
    for (int i = 1; i < DEPTH; i++)
      go(psb_pkg::PSB_CMD_PULL_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("keptbottom", 1'b1, logicAcc);
    go(psb_pkg::PSB_CMD_PUSH_LACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp_word("lvlreset", 32'h0, 32'(stackLevel));
    go(psb_pkg::PSB_CMD_PULL_WACC, 1'b0, 32'h0, 32'h0, psb_pkg::PSB_SZ_BYTE, 1'b0);
    cmp_bit("emptyreset", 1'b1, emptyErr);
  endtask : t_errors
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp_word("lvl0", 32'h0, 32'(stackLevel));
    t_bits();
    t_words();
    t_logic();
    t_errors();
    report_and_stop();
  end
endmodule : tb_top
